//--- rtl/cfg_access_decoder.sv
// processor configuration access decoder for the host bridge
//
// Overview of operation
// - pointer claimed only by dword reads and writes at 0cf8
// - partial pointer access forwarded as plain i/o
// - pointer bit 31 enables configuration access
// - pointer bits 30:24 read as zero
// - pointer bits 23:16 hold target bus
// - pointer bits 15:11 pick the device
// - pointer bits 10:8 pick the function
// - pointer bits 7:2 drive register address
// - data window at 0cfc is 32-bit view
// - enabled window access becomes configuration cycle
// - 4 KB per function, low 256 legacy
// - dword writes reach legacy registers identically by both mechanisms; partial memory writes are dropped
// - extended registers reachable by memory window only
// - port headers carry four extended register bits
// - i/o mechanism forces extended bits to zero
// - base supplies bits 31:28 of window
// - base resets to e, window at e0000000
// - bus zero: local if enabled, else hub
// - secondary bus match gives type 0 on port
// - unclaimed nonzero bus goes type 1 to hub
// - absent function reads ones, drops writes
`timescale 1ns/100ps
module cfg_access_decoder
  import cfg_access_pkg::*;
(
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // processor i/o requests
  input  wire logic               io_req,
  input  wire logic               io_write,
  input  wire logic [15:0]        io_addr,
  input  wire logic [3:0]         io_be,
  input  wire logic [31:0]        io_wdata,
  output logic                    io_ready,
  output logic                    io_ack,
  output logic [31:0]             io_rdata,
  // processor memory requests
  input  wire logic               mem_req,
  input  wire logic               mem_write,
  input  wire logic [31:0]        mem_addr,
  input  wire logic [3:0]         mem_be,
  input  wire logic [31:0]        mem_wdata,
  output logic                    mem_hit,
  output logic                    mem_ready,
  output logic                    mem_ack,
  output logic [31:0]             mem_rdata,
  // plain i/o cycles toward the hub link
  output logic                    hub_io_req,
  output logic                    hub_io_write,
  output logic [15:0]             hub_io_addr,
  output logic [3:0]              hub_io_be,
  output logic [31:0]             hub_io_wdata,
  input  wire logic               hub_io_done,
  input  wire logic [31:0]        hub_io_rdata,
  // configuration cycles toward hub link or ports
  output logic                    cfg_req,
  output logic                    cfg_write,
  output logic                    cfg_on_hub,
  output logic [1:0]              cfg_port,
  output logic                    cfg_type1,
  output logic [7:0]              cfg_bus,
  output logic [4:0]              cfg_dev,
  output logic [2:0]              cfg_func,
  output logic [5:0]              cfg_reg,
  output logic [3:0]              cfg_ext_reg,
  output logic [3:0]              cfg_be,
  output logic [31:0]             cfg_wdata,
  input  wire logic               cfg_done,
  input  wire logic               cfg_abort,
  input  wire logic [31:0]        cfg_rdata,
  // topology
  input  wire logic [31:0]        local_dev_mask,
  input  wire logic [NPORT-1:0]   port_present,
  input  wire logic [NPORT*8-1:0] port_sec_bus,
  input  wire logic [NPORT*8-1:0] port_sub_bus,
  // status
  output logic [3:0]              enhanced_cfg_base,
  output logic                    cfg_access_enable
);

  typedef enum logic [1:0] {ST_IDLE, ST_CFG, ST_HUBIO, ST_DONE} state_t;

  state_t      state;
  logic        resp_is_io;
  logic        cur_write;
  logic [31:0] resp_data;
  logic        base_locked;
  logic [31:0] pointer;
  logic [7:0]  ptr_bus;
  logic [4:0]  ptr_dev;
  logic [2:0]  ptr_func;
  logic [5:0]  ptr_reg;
  logic        take_io;
  logic        take_mem;
  logic        io_is_ptr;
  logic        ptr_claim;
  logic        io_is_win;
  logic        io_forward;
  logic        take_cfg;
  logic [7:0]  next_bus;
  logic [4:0]  next_dev;
  logic [2:0]  next_func;
  logic [9:0]  next_reg;
  logic [3:0]  next_be;
  logic [31:0] next_wdata;
  logic        next_write;
  logic        next_bad_size;
  logic        route_local;
  logic        route_abort;
  logic        route_hub;
  logic        route_type1;
  logic [1:0]  route_port;
  logic [31:0] local_rdata;

  // ----------------------------------------------------------------
  // pointer register and routing
  // ----------------------------------------------------------------
  cfg_target_pointer u_pointer (
    .core_clk          (core_clk),
    .rst               (rst),
    .wr_req            (take_io && io_is_ptr && io_write),
    .wr_be             (io_be),
    .wr_data           (io_wdata),
    .pointer           (pointer),
    .cfg_access_enable (cfg_access_enable),
    .ptr_bus           (ptr_bus),
    .ptr_dev           (ptr_dev),
    .ptr_func          (ptr_func),
    .ptr_reg           (ptr_reg)
  );

  cfg_route_decode u_route (
    .bus            (next_bus),
    .dev            (next_dev),
    .func           (next_func),
    .local_dev_mask (local_dev_mask),
    .port_present   (port_present),
    .port_sec_bus   (port_sec_bus),
    .port_sub_bus   (port_sub_bus),
    .route_local    (route_local),
    .route_abort    (route_abort),
    .route_hub      (route_hub),
    .route_type1    (route_type1),
    .route_port     (route_port)
  );

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  assign io_ready   = (state == ST_IDLE);
  assign mem_ready  = (state == ST_IDLE) && !io_req;
  assign mem_hit    = (mem_addr[31:ENH_BASE_LSB] == enhanced_cfg_base);
  assign take_io    = io_req && io_ready;
  assign take_mem   = mem_req && mem_hit && mem_ready;
  assign io_is_ptr  = (io_addr == IO_PTR_PORT);
  assign ptr_claim  = io_is_ptr && dword_full(io_be);
  assign io_is_win  = (io_addr == IO_DATA_PORT) && cfg_access_enable;
  assign io_forward = take_io && !ptr_claim && !io_is_win;
  assign take_cfg   = (take_io && io_is_win) || take_mem;

  always_comb begin
    if (take_mem) begin
      next_bus      = mem_addr[ENH_BUS_LSB +: 8];
      next_dev      = mem_addr[ENH_DEV_LSB +: 5];
      next_func     = mem_addr[ENH_FUNC_LSB +: 3];
      next_reg      = mem_addr[ENH_REG_LSB +: 10];
      next_be       = mem_be;
      next_wdata    = mem_wdata;
      next_write    = mem_write;
      next_bad_size = !dword_full(mem_be);
    end else begin
      next_bus      = ptr_bus;
      next_dev      = ptr_dev;
      next_func     = ptr_func;
      next_reg      = {4'h0, ptr_reg};
      next_be       = io_be;
      next_wdata    = io_wdata;
      next_write    = io_write;
      next_bad_size = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // local function: only the enhanced base dword is implemented
  // ----------------------------------------------------------------
  assign local_rdata = (next_reg == BASE_REG_INDEX) ? {enhanced_cfg_base, 28'h0} : 32'h0;

  // write-once base, set by an i/o write with byte 3 enabled or by a full-dword memory write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enhanced_cfg_base <= ENH_BASE_RESET;
      base_locked       <= 1'b0;
    end else if (take_cfg && route_local && !next_bad_size && next_write && next_reg == BASE_REG_INDEX
                 && next_be[3] && !base_locked) begin
      enhanced_cfg_base <= next_wdata[31:ENH_BASE_LSB];
      base_locked       <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take_io && ptr_claim) begin
            state <= ST_DONE;
          end else if (io_forward) begin
            state <= ST_HUBIO;
          end else if (take_cfg) begin
            state <= (route_local || route_abort || next_bad_size) ? ST_DONE : ST_CFG;
          end
        end
        ST_CFG:   if (cfg_done) state <= ST_DONE;
        ST_HUBIO: if (hub_io_done) state <= ST_DONE;
        ST_DONE:  state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  // answer data and which side gets the acknowledge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      resp_data    <= WINDOW_RESET;
      resp_is_io   <= 1'b0;
      cur_write    <= 1'b0;
    end else if (state == ST_IDLE && (take_io || take_mem)) begin
      resp_is_io   <= take_io;
      cur_write    <= take_io ? io_write : mem_write;
      if (take_io && ptr_claim) begin
        resp_data <= io_write ? 32'h0 : pointer;
      end else if (take_cfg && !next_write && (route_abort || next_bad_size)) begin
        resp_data <= ALL_ONES;
      end else if (take_cfg && !next_write && route_local) begin
        resp_data <= local_rdata;
      end else begin
        resp_data <= 32'h0;
      end
    end else if (state == ST_CFG && cfg_done && !cur_write) begin
      resp_data <= cfg_abort ? ALL_ONES : cfg_rdata;
    end else if (state == ST_HUBIO && hub_io_done && !cur_write) begin
      resp_data <= hub_io_rdata;
    end
  end

  assign io_ack    = (state == ST_DONE) && resp_is_io;
  assign mem_ack   = (state == ST_DONE) && !resp_is_io;
  assign io_rdata  = resp_data;
  assign mem_rdata = resp_data;

  // ----------------------------------------------------------------
  // outbound cycles, fields latched at acceptance
  // ----------------------------------------------------------------
  assign cfg_req    = (state == ST_CFG);
  assign hub_io_req = (state == ST_HUBIO);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_write   <= 1'b0;
      cfg_on_hub  <= 1'b0;
      cfg_port    <= 2'd0;
      cfg_type1   <= 1'b0;
      cfg_bus     <= 8'h00;
      cfg_dev     <= 5'h00;
      cfg_func    <= 3'h0;
      cfg_reg     <= 6'h00;
      cfg_ext_reg <= 4'h0;
      cfg_be      <= 4'h0;
      cfg_wdata   <= 32'h0;
    end else if (take_cfg) begin
      cfg_write   <= next_write;
      cfg_on_hub  <= route_hub;
      cfg_port    <= route_port;
      cfg_type1   <= route_type1;
      cfg_bus     <= next_bus;
      cfg_dev     <= next_dev;
      cfg_func    <= next_func;
      cfg_reg     <= next_reg[5:0];
      cfg_ext_reg <= next_reg[9:6];
      cfg_be      <= next_be;
      cfg_wdata   <= next_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hub_io_write <= 1'b0;
      hub_io_addr  <= 16'h0000;
      hub_io_be    <= 4'h0;
      hub_io_wdata <= 32'h0;
    end else if (io_forward) begin
      hub_io_write <= io_write;
      hub_io_addr  <= io_addr;
      hub_io_be    <= io_be;
      hub_io_wdata <= io_wdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_window_take;
    take_io && io_is_win && !route_local && !route_abort;
  endsequence

  sequence s_cfg_issue;
    cfg_req && cfg_ext_reg == 4'h0 && cfg_bus == $past(ptr_bus) && cfg_reg == $past(ptr_reg);
  endsequence

  a_ptr_partial_kept: assert property (
    take_io && io_is_ptr && io_write && !dword_full(io_be) |=> $stable(pointer))
    else $error("partial write changed the pointer");

  a_ptr_reserved_zero: assert property (
    pointer[30:24] == 7'h00 && pointer[1:0] == 2'h0)
    else $error("pointer reserved bits not zero");

  a_partial_forwarded: assert property (
    take_io && io_is_ptr && !dword_full(io_be) |=> hub_io_req && hub_io_addr == IO_PTR_PORT)
    else $error("partial pointer access not forwarded");

  a_window_disabled_io: assert property (
    take_io && io_addr == IO_DATA_PORT && !cfg_access_enable |=> hub_io_req && !cfg_req)
    else $error("disabled window made a configuration cycle");

  a_window_to_cfg: assert property (
    s_window_take |=> s_cfg_issue)
    else $error("window access not translated from pointer");

  a_cfg_held: assert property (
    cfg_req && !cfg_done |=> cfg_req && $stable(cfg_bus) && $stable(cfg_reg))
    else $error("configuration request dropped before done");

  a_abort_all_ones: assert property (
    state == ST_CFG && cfg_done && cfg_abort && !cur_write |=> resp_data == ALL_ONES ##0 (io_ack || mem_ack))
    else $error("aborted read did not return all ones");

  a_base_reset_value: assert property (
    !base_locked |-> enhanced_cfg_base == ENH_BASE_RESET)
    else $error("enhanced base left its reset value");

  a_mem_fields: assert property (
    take_mem && !route_local && !route_abort && dword_full(mem_be)
    |=> cfg_req && cfg_bus == $past(mem_addr[27:20]) && {cfg_ext_reg, cfg_reg} == $past(mem_addr[11:2]))
    else $error("memory window fields decoded wrongly");

endmodule : cfg_access_decoder

//--- rtl/cfg_access_pkg.sv
// shared constants and helpers for the configuration access decoder
package cfg_access_pkg;

  // ----------------------------------------------------------------
  // i/o port map
  // ----------------------------------------------------------------
  localparam logic [15:0] IO_PTR_PORT    = 16'h0cf8;
  localparam logic [15:0] IO_DATA_PORT   = 16'h0cfc;
  localparam logic [31:0] PTR_RESET      = 32'h0000_0000;
  localparam logic [31:0] WINDOW_RESET   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // pointer field layout
  // ----------------------------------------------------------------
  localparam int PTR_ENABLE_BIT = 31;
  localparam int PTR_BUS_LSB    = 16;
  localparam int PTR_DEV_LSB    = 11;
  localparam int PTR_FUNC_LSB   = 8;
  localparam int PTR_REG_LSB    = 2;

  // ----------------------------------------------------------------
  // enhanced window layout
  // ----------------------------------------------------------------
  localparam int          ENH_BASE_LSB   = 28;
  localparam int          ENH_BUS_LSB    = 20;
  localparam int          ENH_DEV_LSB    = 15;
  localparam int          ENH_FUNC_LSB   = 12;
  localparam int          ENH_REG_LSB    = 2;
  localparam logic [3:0]  ENH_BASE_RESET = 4'he;

  // ----------------------------------------------------------------
  // local function and topology
  // ----------------------------------------------------------------
  localparam int          NPORT          = 3;
  localparam logic [9:0]  BASE_REG_INDEX = 10'h033;
  localparam logic [31:0] ALL_ONES       = 32'hffff_ffff;
  localparam logic [3:0]  BE_DWORD       = 4'hf;

  function automatic logic dword_full(input logic [3:0] be);
    return be == BE_DWORD;
  endfunction : dword_full

endpackage : cfg_access_pkg

//--- rtl/cfg_target_pointer.sv
// configuration target pointer register
`timescale 1ns/100ps
module cfg_target_pointer
  import cfg_access_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // write port
  input  wire logic        wr_req,
  input  wire logic [3:0]  wr_be,
  input  wire logic [31:0] wr_data,
  // pointer contents
  output logic [31:0]      pointer,
  output logic             cfg_access_enable,
  output logic [7:0]       ptr_bus,
  output logic [4:0]       ptr_dev,
  output logic [2:0]       ptr_func,
  output logic [5:0]       ptr_reg
);

  logic        enable_bit;
  logic [23:2] target;

  // only whole-dword writes land
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enable_bit <= PTR_RESET[PTR_ENABLE_BIT];
      target     <= PTR_RESET[23:2];
    end else if (wr_req && dword_full(wr_be)) begin
      enable_bit <= wr_data[PTR_ENABLE_BIT];
      target     <= wr_data[23:2];
    end
  end

  assign pointer           = {enable_bit, 7'h00, target, 2'h0};
  assign cfg_access_enable = enable_bit;
  assign ptr_bus           = pointer[PTR_BUS_LSB +: 8];
  assign ptr_dev           = pointer[PTR_DEV_LSB +: 5];
  assign ptr_func          = pointer[PTR_FUNC_LSB +: 3];
  assign ptr_reg           = pointer[PTR_REG_LSB +: 6];

endmodule : cfg_target_pointer

//--- rtl/cfg_route_decode.sv
// routing of a configuration target to local, hub link or a port
`timescale 1ns/100ps
module cfg_route_decode
  import cfg_access_pkg::*;
(
  // target
  input  wire logic [7:0]         bus,
  input  wire logic [4:0]         dev,
  input  wire logic [2:0]         func,
  // topology
  input  wire logic [31:0]        local_dev_mask,
  input  wire logic [NPORT-1:0]   port_present,
  input  wire logic [NPORT*8-1:0] port_sec_bus,
  input  wire logic [NPORT*8-1:0] port_sub_bus,
  // route
  output logic                    route_local,
  output logic                    route_abort,
  output logic                    route_hub,
  output logic                    route_type1,
  output logic [1:0]              route_port
);

  always_comb begin
    route_local = 1'b0;
    route_abort = 1'b0;
    route_hub   = 1'b1;
    route_type1 = 1'b0;
    route_port  = 2'd0;
    if (bus == 8'h00) begin
      if (local_dev_mask[dev]) begin
        route_hub   = 1'b0;
        route_local = (func == 3'd0);
        route_abort = (func != 3'd0);
      end
    end else begin
      route_type1 = 1'b1;
      for (int p = NPORT - 1; p >= 0; p--) begin
        if (bus >= port_sec_bus[p*8 +: 8] && bus <= port_sub_bus[p*8 +: 8]) begin
          route_hub   = 1'b0;
          route_abort = !port_present[p];
          route_type1 = (bus != port_sec_bus[p*8 +: 8]);
          route_port  = p[1:0];
        end
      end
    end
  end

endmodule : cfg_route_decode

//--- testbench/cfg_link_responder.sv
// link-side responder for configuration and forwarded i/o cycles
`timescale 1ns/100ps
module cfg_link_responder (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // control from bench
  input  wire logic [3:0]  delay,
  input  wire logic        abort_en,
  input  wire logic [31:0] resp_data,
  // link requests and answers
  input  wire logic        cfg_req,
  input  wire logic        hub_io_req,
  output logic             cfg_done,
  output logic             cfg_abort,
  output logic [31:0]      cfg_rdata,
  output logic             hub_io_done,
  output logic [31:0]      hub_io_rdata
);
  logic [3:0] cnt;

  // ----------------------------------------------------------------
  // answer after delay cycles, off the falling edge
  // ----------------------------------------------------------------
  always @(negedge core_clk or posedge rst) begin
    if (rst) begin
      cnt         <= 4'h0;
      cfg_done    <= 1'b0;
      hub_io_done <= 1'b0;
    end else begin
      cfg_done    <= cfg_req && !cfg_done && cnt >= delay;
      hub_io_done <= hub_io_req && !hub_io_done && cnt >= delay;
      cnt         <= ((cfg_req || hub_io_req) && !cfg_done && !hub_io_done) ? cnt + 4'h1 : 4'h0;
    end
  end

  // data lines show an inverted pattern outside the answer cycle
  assign cfg_abort    = cfg_done && abort_en;
  assign cfg_rdata    = cfg_done ? resp_data : ~resp_data;
  assign hub_io_rdata = hub_io_done ? resp_data : ~resp_data;
endmodule : cfg_link_responder

//--- testbench/pci_config_access_decoder_tb.sv
// self-checking bench for the configuration access decoder
`timescale 1ns/100ps
module pci_config_access_decoder_tb;
  import cfg_access_pkg::*;
  logic               core_clk = 1'b0, rst = 1'b1, abort_en = 1'b0;
  logic               io_req = 1'b0, io_write = 1'b0, mem_req = 1'b0, mem_write = 1'b0;
  logic [15:0]        io_addr = 16'h0, hub_io_addr;
  logic [3:0]         io_be = 4'h0, mem_be = 4'h0, delay = 4'h0, hub_io_be, cfg_ext_reg, cfg_be, enhanced_cfg_base;
  logic [31:0]        io_wdata = 32'h0, mem_addr = 32'h0, mem_wdata = 32'h0, resp_data = 32'h0;
  logic [31:0]        local_dev_mask = 32'h5, io_rdata, mem_rdata, hub_io_wdata, cfg_wdata, cfg_rdata, hub_io_rdata;
  logic [NPORT-1:0]   port_present = 3'b011;
  logic [NPORT*8-1:0] port_sec_bus = {8'h14, 8'h08, 8'h02}, port_sub_bus = {8'h16, 8'h0c, 8'h05};
  logic               io_ready, io_ack, mem_hit, mem_ready, mem_ack, hub_io_req, hub_io_write, hub_io_done;
  logic               cfg_req, cfg_write, cfg_on_hub, cfg_type1, cfg_done, cfg_abort, cfg_access_enable;
  logic [1:0]         cfg_port;
  logic [7:0]         cfg_bus;
  logic [4:0]         cfg_dev;
  logic [2:0]         cfg_func;
  logic [5:0]         cfg_reg;
  logic [34:0]        cap_cfg;
  logic [52:0]        cap_hub;
  logic [31:0]        cap_wd, rd, w;
  logic [3:0]         exp_base = 4'he;
  logic               base_set = 1'b0;
  logic [7:0]         buses [8] = '{8'h00, 8'h02, 8'h03, 8'h05, 8'h06, 8'h08, 8'h0a, 8'h14};
  int                 n_mismatch = 0, checks_done = 0, n_cfg = 0, n_hub = 0, seed = 14, n0;

  cfg_access_decoder i_cfg_access_decoder (.*);
  cfg_link_responder i_cfg_link_responder (.*);

  always #5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // capture of finished link cycles
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (cfg_req && cfg_done) begin
      cap_cfg <= {cfg_write, cfg_on_hub, cfg_port, cfg_type1, cfg_bus, cfg_dev, cfg_func, cfg_reg, cfg_ext_reg, cfg_be};
      cap_wd  <= cfg_wdata;
      n_cfg   <= n_cfg + 1;
    end
    if (hub_io_req && hub_io_done) begin
      cap_hub <= {hub_io_write, hub_io_addr, hub_io_be, hub_io_wdata};
      n_hub   <= n_hub + 1;
    end
  end

  // ----------------------------------------------------------------
  // tasks and expectation
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic final_report();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // kind in bits 3:2: local, abort, hub, port; type 1 in bit 4
  function automatic logic [4:0] exp_route(input logic [7:0] b, input logic [4:0] d, input logic [2:0] f);
    if (b == 8'h00) return local_dev_mask[d] ? (f == 3'h0 ? 5'h00 : 5'h04) : 5'h08;
    for (int p = 0; p < 3; p++) begin
      if (b >= port_sec_bus[8*p+:8] && b <= port_sub_bus[8*p+:8])
        return port_present[p] ? {b != port_sec_bus[8*p+:8], 2'h3, p[1:0]} : 5'h04;
    end
    return 5'h18;
  endfunction : exp_route

  task automatic host_op(input logic m, input logic wr, input logic [31:0] a, input logic [3:0] be,
                         input logic [31:0] wd, output logic [31:0] r);
    int i;
    i = 0;
    @(negedge core_clk);
    {io_write, io_addr, io_be, io_wdata} = {wr, a[15:0], be, wd};
    {mem_write, mem_addr, mem_be, mem_wdata} = {wr, a, be, wd};
    io_req = !m;
    mem_req = m;
    while (!(m ? mem_ready : io_ready) && i < 100) begin
      @(negedge core_clk);
      i++;
    end
    @(negedge core_clk);
    io_req = 1'b0;
    mem_req = 1'b0;
    while (!(m ? mem_ack : io_ack) && i < 100) begin
      @(negedge core_clk);
      i++;
    end
    r = m ? mem_rdata : io_rdata;
    if (i >= 100) chk("handshake", 64'h0, 64'h1);
  endtask : host_op

  task automatic do_cfg(input logic m, input logic wr, input logic [7:0] b, input logic [4:0] d,
                        input logic [2:0] f, input logic [9:0] rg, input logic [3:0] be, input logic [31:0] wd);
    logic [4:0]  rt;
    logic [9:0]  ix;
    logic [31:0] e;
    logic [31:0] r;
    int          c0;
    rt = (m && be != 4'hf) ? 5'h04 : exp_route(b, d, f);
    ix = {m ? rg[9:6] : 4'h0, rg[5:0]};
    if (!m) host_op(1'b0, 1'b1, 32'hcf8, 4'hf, {1'b1, 7'h0, b, d, f, rg[5:0], 2'b00}, r);
    c0 = n_cfg;
    host_op(m, wr, m ? {exp_base, b, d, f, rg, 2'b00} : 32'hcfc, be, wd, r);
    if (rt[3:2] == 2'h0 && wr && ix == BASE_REG_INDEX && be[3] && !base_set) begin
      exp_base = wd[31:28];
      base_set = 1'b1;
    end
    if (rt[3]) begin
      chk("cfg count", c0 + 1, n_cfg);
      chk("cfg fields", {wr, !rt[2], rt[2] ? rt[1:0] : cap_cfg[32:31], rt[4], b, d, f, ix[5:0], ix[9:6], be},
          cap_cfg);
      if (wr) chk("cfg wdata", wd, cap_wd);
      e = wr ? 32'h0 : abort_en ? ALL_ONES : resp_data;
    end else begin
      chk("cfg count", c0, n_cfg);
      e = wr ? 32'h0 : rt[2] ? ALL_ONES : (ix == BASE_REG_INDEX ? {exp_base, 28'h0} : 32'h0);
    end
    chk("read data", e, r);
    chk("window base", exp_base, enhanced_cfg_base);
  endtask : do_cfg

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    chk("base reset", 4'he, enhanced_cfg_base);
    host_op(1'b0, 1'b0, 32'hcf8, 4'hf, 32'h0, rd);
    chk("pointer reset", 32'h0, rd);
    w = $random(seed) | 32'h7f00_0003;
    host_op(1'b0, 1'b1, 32'hcf8, 4'hf, w, rd);
    host_op(1'b0, 1'b0, 32'hcf8, 4'hf, 32'h0, rd);
    chk("pointer", w & 32'h80ff_fffc, rd);
    chk("enable", w[31], cfg_access_enable);
    for (int k = 0; k < 3; k++) begin
      host_op(1'b0, 1'b1, 32'hcf8, 4'h3 << k, ~w, rd);
      chk("hub cycle", {1'b1, 16'h0cf8, 4'h3 << k, ~w}, cap_hub);
    end
    host_op(1'b0, 1'b0, 32'hcf8, 4'hf, 32'h0, rd);
    chk("pointer kept", w & 32'h80ff_fffc, rd);
    host_op(1'b0, 1'b1, 32'hcf8, 4'hf, 32'h0012_3400, rd);
    resp_data = $random(seed);
    n0 = n_cfg;
    host_op(1'b0, 1'b0, 32'hcfc, 4'hf, 32'h0, rd);
    chk("disabled window", {1'b0, 16'h0cfc, 4'hf, resp_data}, {cap_hub[52:32], rd});
    chk("disabled count", n0, n_cfg);
    local_dev_mask = 32'h1;
    do_cfg(1'b0, 1'b1, 8'h00, 5'h00, 3'h0, 10'h033, 4'hf, 32'hc123_4567);
    do_cfg(1'b1, 1'b0, 8'h00, 5'h00, 3'h0, 10'h033, 4'hf, 32'h0);
    do_cfg(1'b1, 1'b1, 8'h00, 5'h00, 3'h0, 10'h033, 4'hf, 32'h5000_0000);
    do_cfg(1'b1, 1'b0, 8'h00, 5'h00, 3'h0, 10'h133, 4'hf, 32'h0);
    @(negedge core_clk);
    mem_addr = 32'he000_0000;
    #1 chk("hit outside", 1'b0, mem_hit);
    mem_addr = 32'hcfff_fffc;
    #1 chk("hit inside", 1'b1, mem_hit);
    for (int k = 0; k < 48; k++) begin
      local_dev_mask = $random(seed);
      delay = 4'($random(seed)) & 4'h5;
      abort_en = ($random(seed) & 3) == 0;
      resp_data = $random(seed);
      w = $random(seed);
      do_cfg(w[0], w[1], buses[w[4:2]], w[9:5], w[12] ? 3'h0 : w[15:13], w[25:16],
             (!w[0] && w[26] && w[30:27] != 4'h0) ? w[30:27] : 4'hf, $random(seed));
    end
    final_report();
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    final_report();
  end
endmodule : pci_config_access_decoder_tb
